// File: inc/ddc_pkg.sv
/*
  Package for the dual converter control block: register offsets, field
  positions, reset values and select encodings.
  Assumes a Wishbone slave with byte addresses and 32-bit data words.
*/
package ddc_pkg;

  // Printed offsets are not all word aligned, so they are indices
  localparam logic [11:0] DDC_IDX_CTRL1 = 12'h88C;
  localparam logic [11:0] DDC_IDX_CODE1 = 12'h88D;
  localparam logic [11:0] DDC_IDX_CTRL2 = 12'h890;
  localparam logic [11:0] DDC_IDX_CODE2 = 12'h891;
  localparam logic [11:0] DDC_IDX_STAT  = 12'h892;
  localparam int          DDC_ADDR_W    = 14;

  // Control register fields
  localparam int DDC_BIT_EN   = 7;
  localparam int DDC_BIT_RNG  = 6;
  localparam int DDC_OE_HI    = 5;
  localparam int DDC_OE_LO    = 4;
  localparam int DDC_PSS_HI   = 3;
  localparam int DDC_PSS_LO   = 2;
  localparam int DDC_BIT_NSS  = 0;
  localparam logic [7:0] DDC_CTRL_WMASK = 8'hFD;

  // Reset values
  localparam logic [7:0] DDC_CTRL_RST = 8'h00;
  localparam logic [7:0] DDC_CODE_RST = 8'h00;

  // Output enable codes
  localparam logic [1:0] DDC_OE_PIN2 = 2'h2;
  localparam logic [1:0] DDC_OE_PIN1 = 2'h1;

  // Positive reference codes
  localparam logic [1:0] DDC_PSS_SUPPLY = 2'h0;
  localparam logic [1:0] DDC_PSS_EXTPIN = 2'h1;
  localparam logic [1:0] DDC_PSS_FIXREF = 2'h2;

  // Automatic range threshold: codes at or above pick high range
  localparam logic [7:0] DDC_AUTO_HI_CODE = 8'h80;

  // Reference select one-hot outputs: supply, ext pin, fixed reference
  localparam int DDC_NREF = 3;

endpackage

// File: logic/ddc_code_store.sv
/*
  Two-entry store for the level codes of both converter instances.
  Read data comes out of a register. Assumes one clock and async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_code_store
  import ddc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       wr_en,
  input  wire logic       wr_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_sel,
  output logic      [7:0] rd_data,
  output logic      [7:0] code0,
  output logic      [7:0] code1
);

  logic [7:0] mem_q [2];

  ////////////////////////////////////////////////////////////////////////
  // Storage; reset clears both codes
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_ent
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_q[i] <= DDC_CODE_RST;
        end else if (wr_en && (wr_sel == 1'(i))) begin
          mem_q[i] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= DDC_CODE_RST;
    end else begin
      rd_data <= mem_q[rd_sel];
    end
  end

  assign code0 = mem_q[0];
  assign code1 = mem_q[1];

endmodule
`default_nettype wire

// File: logic/ddc_top.sv
/*
  Control logic for two 8-bit voltage converter instances behind a classic
  Wishbone slave. Drives the analog enables, reference selects, range and
  pin output enables; the ladder and buffer sit outside.
  Assumes SLEEP and AUTO_RANGE_CFG come from other clock domains or pins.
*/
// How it works
// - Control bit 7 enables each instance
// - Instance one drives pins, two internal only
// - Level code passed to ladder unchanged
// - At most one pin output driven
// - OE 10 pin two, 01 pin one
// - Positive reference: supply, ext pin, fixed
// - Auto cfg one: software range bit rules
// - Auto cfg zero: range from code
// - Sleep wake keeps register contents
// - Reference switched off during sleep
// - Reset disables, unpowers pins, clears codes
// - Control bit 0 picks negative reference
// - Range bit only affects instance one pins
// - Separate eight-bit code register, resets zero
`timescale 1ns/1ps
`default_nettype none
module ddc_top
  import ddc_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_B,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [DDC_ADDR_W-1:0] WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  input  wire logic                  SLEEP,
  input  wire logic                  AUTO_RANGE_CFG,
  output logic                       DAC1_EN,
  output logic      [7:0]            DAC1_LEVEL_CODE,
  output logic      [DDC_NREF-1:0]   DAC1_POS_REF,
  output logic                       DAC1_NEG_REF_EXT,
  output logic                       DAC1_RANGE_HIGH,
  output logic                       DAC1_PIN1_OUT_EN,
  output logic                       DAC1_PIN2_OUT_EN,
  output logic                       DAC2_EN,
  output logic      [7:0]            DAC2_LEVEL_CODE,
  output logic      [DDC_NREF-1:0]   DAC2_POS_REF,
  output logic                       DAC2_NEG_REF_EXT
);

  logic [7:0]  ctrl_q [2];
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        sleep_s1_q, sleep_q;
  logic        auto_s1_q, auto_s2_q;
  logic        auto_cfg_q;
  logic [2:0]  auto_done_q;
  logic [1:0]  rd_src_q;
  logic [7:0]  code_rd;
  logic [7:0]  code0, code1;
  logic        req;
  logic        hit_ctrl1, hit_ctrl2, hit_code1, hit_code2, hit_stat;
  logic        code_wr;
  logic        ref_live1, ref_live2;
  logic        pin1_d, pin2_d;
  logic        range1_d;
  logic [2:0]  pos1_d, pos2_d;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; printed offsets are word indices
  assign req       = WB_CYC_I && WB_STB_I && !ack_q;
  assign hit_ctrl1 = (WB_ADR_I[DDC_ADDR_W-1:2] == DDC_IDX_CTRL1);
  assign hit_ctrl2 = (WB_ADR_I[DDC_ADDR_W-1:2] == DDC_IDX_CTRL2);
  assign hit_code1 = (WB_ADR_I[DDC_ADDR_W-1:2] == DDC_IDX_CODE1);
  assign hit_code2 = (WB_ADR_I[DDC_ADDR_W-1:2] == DDC_IDX_CODE2);
  assign hit_stat  = (WB_ADR_I[DDC_ADDR_W-1:2] == DDC_IDX_STAT);
  assign code_wr   = req && WB_WE_I && WB_SEL_I[0] && (hit_code1 || hit_code2);

  // Ack one cycle after the request; dropped the next cycle
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control registers; bit 1 is unimplemented and reads zero.
  // Sleep does not touch them, so wake keeps the contents.
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_ctrl
      always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          ctrl_q[k] <= DDC_CTRL_RST;
        end else if (req && WB_WE_I && WB_SEL_I[0] && ((k == 0) ? hit_ctrl1 : hit_ctrl2)) begin
          ctrl_q[k] <= WB_DAT_I[7:0] & DDC_CTRL_WMASK;
        end
      end
    end
  endgenerate

  // Level code store, one register per instance
  ddc_code_store u_codes (
    .clk     (REF_CLK),
    .rst_b   (RST_B),
    .wr_en   (code_wr),
    .wr_sel  (hit_code2),
    .wr_data (WB_DAT_I[7:0]),
    .rd_sel  (hit_code2),
    .rd_data (code_rd),
    .code0   (code0),
    .code1   (code1)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read path: source picked in the request cycle, muxed at ack time
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_src_q <= 2'h0;
      rdat_q   <= 32'h0000_0000;
    end else if (req) begin
      rd_src_q <= (hit_code1 || hit_code2) ? 2'h1 : 2'h0;
      if (hit_ctrl1) begin
        rdat_q <= {24'h00_0000, ctrl_q[0]};
      end else if (hit_ctrl2) begin
        rdat_q <= {24'h00_0000, ctrl_q[1]};
      end else if (hit_stat) begin
        rdat_q <= {24'h00_0000, 5'h00, DAC1_RANGE_HIGH, sleep_q, auto_cfg_q};
      end else begin
        rdat_q <= 32'h0000_0000;                 // Unmapped reads zero
      end
    end
  end

  // Code read data comes registered from the store in the same cycle
  always_comb begin
    if (rd_src_q == 2'h1) begin
      WB_DAT_O = {24'h00_0000, code_rd};
    end else begin
      WB_DAT_O = rdat_q;
    end
  end
  assign WB_ACK_O = ack_q;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for the sleep level and the configuration strap
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sleep_s1_q <= 1'b0;
      sleep_q    <= 1'b0;
      auto_s1_q  <= 1'b0;
      auto_s2_q  <= 1'b0;
    end else begin
      sleep_s1_q <= SLEEP;
      sleep_q    <= sleep_s1_q;
      auto_s1_q  <= AUTO_RANGE_CFG;
      auto_s2_q  <= auto_s1_q;
    end
  end

  // Strap is followed for the first three edges after reset release, so
  // the last copy taken has passed both synchroniser stages, then frozen;
  // defaults to hardware ranging until then
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      auto_done_q <= 3'h0;
      auto_cfg_q  <= 1'b0;
    end else if (!auto_done_q[2]) begin
      auto_done_q <= {auto_done_q[1:0], 1'b1};
      auto_cfg_q  <= auto_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next values for the analog controls. Each decode sits in its own
  // process so the registered outputs below stay plain copies, and every
  // pin-facing output still leaves from a flip-flop without a glitch when
  // two control fields change in the same write.

  // Reference stays live only while the instance is enabled and the part
  // is awake. Sleep cuts the reference to save current, but leaves the
  // control and code registers alone so wake resumes where it stopped.
  assign ref_live1 = !sleep_q && ctrl_q[0][DDC_BIT_EN];
  assign ref_live2 = !sleep_q && ctrl_q[1][DDC_BIT_EN];

  // Positive reference for instance one, one-hot. The reserved code
  // selects no source: opening every switch is safer than guessing.
  always_comb begin
    pos1_d = '0;
    unique case (ctrl_q[0][DDC_PSS_HI:DDC_PSS_LO])
      DDC_PSS_SUPPLY: begin
        pos1_d[0] = ref_live1;
      end
      DDC_PSS_EXTPIN: begin
        pos1_d[1] = ref_live1;
      end
      DDC_PSS_FIXREF: begin
        pos1_d[2] = ref_live1;
      end
      2'h3: begin
        pos1_d = '0;                                             // Reserved
      end
    endcase
  end

  // Positive reference for instance two, same decode as instance one
  always_comb begin
    pos2_d = '0;
    unique case (ctrl_q[1][DDC_PSS_HI:DDC_PSS_LO])
      DDC_PSS_SUPPLY: begin
        pos2_d[0] = ref_live2;
      end
      DDC_PSS_EXTPIN: begin
        pos2_d[1] = ref_live2;
      end
      DDC_PSS_FIXREF: begin
        pos2_d[2] = ref_live2;
      end
      2'h3: begin
        pos2_d = '0;                                             // Reserved
      end
    endcase
  end

  // Output enables of instance one. Only the codes 01 and 10 pick a pin;
  // 00 and 11 leave both pins undriven, so the pair is never on together
  // whatever software writes. A disabled instance drives no pin at all.
  always_comb begin
    pin1_d = 1'b0;
    pin2_d = 1'b0;
    unique case (ctrl_q[0][DDC_OE_HI:DDC_OE_LO])
      DDC_OE_PIN1: begin
        pin1_d = ctrl_q[0][DDC_BIT_EN];
      end
      DDC_OE_PIN2: begin
        pin2_d = ctrl_q[0][DDC_BIT_EN];
      end
      2'h0, 2'h3: begin
        pin1_d = 1'b0;
        pin2_d = 1'b0;
      end
    endcase
  end

  // Buffer range of instance one. With the strap high software owns the
  // range bit; with it low the code picks the range and the software bit
  // is ignored. A fixed midscale compare is the simplest rule that keeps
  // the buffer biased towards the rail the output is nearest.
  always_comb begin
    if (auto_cfg_q) begin
      range1_d = ctrl_q[0][DDC_BIT_RNG];
    end else begin
      range1_d = (code0 >= DDC_AUTO_HI_CODE);
    end
  end

  // Instance one outputs, all registered
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DAC1_EN          <= 1'b0;
      DAC1_LEVEL_CODE  <= DDC_CODE_RST;
      DAC1_POS_REF     <= '0;
      DAC1_NEG_REF_EXT <= 1'b0;
      DAC1_RANGE_HIGH  <= 1'b0;
      DAC1_PIN1_OUT_EN <= 1'b0;
      DAC1_PIN2_OUT_EN <= 1'b0;
    end else begin
      DAC1_EN          <= ctrl_q[0][DDC_BIT_EN];
      DAC1_LEVEL_CODE  <= code0;
      DAC1_POS_REF     <= pos1_d;
      DAC1_NEG_REF_EXT <= ctrl_q[0][DDC_BIT_NSS];
      // Range only steers the pin buffer of instance one
      DAC1_RANGE_HIGH  <= range1_d;
      DAC1_PIN1_OUT_EN <= pin1_d;
      DAC1_PIN2_OUT_EN <= pin2_d;
    end
  end

  // Instance two feeds internal consumers only; its OE and range bits
  // are stored but steer nothing
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DAC2_EN          <= 1'b0;
      DAC2_LEVEL_CODE  <= DDC_CODE_RST;
      DAC2_POS_REF     <= '0;
      DAC2_NEG_REF_EXT <= 1'b0;
    end else begin
      DAC2_EN          <= ctrl_q[1][DDC_BIT_EN];
      DAC2_LEVEL_CODE  <= code1;
      DAC2_POS_REF     <= pos2_d;
      DAC2_NEG_REF_EXT <= ctrl_q[1][DDC_BIT_NSS];
    end
  end

endmodule
`default_nettype wire

// File: verification/ddc_checker.sv
/* Checker for ddc_top: DAC1 outputs against shadow copies of bus writes.
   Assumes ddc_pkg is compiled first and the bind below reaches ddc_top. */
`timescale 1ns/1ps
`default_nettype none
module ddc_checker
  import ddc_pkg::*;
(
  input wire logic                  REF_CLK,
  input wire logic                  RST_B,
  input wire logic                  WB_WE_I,
  input wire logic [DDC_ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0]            WB_SEL_I,
  input wire logic [31:0]           WB_DAT_I,
  input wire logic                  WB_ACK_O,
  input wire logic                  SLEEP,
  input wire logic                  AUTO_RANGE_CFG,
  input wire logic                  DAC1_EN,
  input wire logic [7:0]            DAC1_LEVEL_CODE,
  input wire logic [DDC_NREF-1:0]   DAC1_POS_REF,
  input wire logic                  DAC1_NEG_REF_EXT,
  input wire logic                  DAC1_RANGE_HIGH,
  input wire logic                  DAC1_PIN1_OUT_EN,
  input wire logic                  DAC1_PIN2_OUT_EN
);
  logic [7:0] ctl_q;
  logic [7:0] cod_q;
  logic [1:0] qt_q;
  logic       wr;
  logic       st;
  assign wr = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  assign st = qt_q == 2'h2;
  ////////////////////////////////
  // Shadow of accepted DAC1 writes
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_q <= 8'h00;
      cod_q <= 8'h00;
    end else if (wr && WB_ADR_I == {DDC_IDX_CTRL1, 2'h0}) begin
      ctl_q <= WB_DAT_I[7:0];
    end else if (wr && WB_ADR_I == {DDC_IDX_CODE1, 2'h0}) begin
      cod_q <= WB_DAT_I[7:0];
    end
  end
  // Outputs trail a write by up to two edges, so judge them only once settled
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      qt_q <= 2'h0;
    end else if (WB_ACK_O) begin
      qt_q <= 2'h0;
    end else if (!st) begin
      qt_q <= qt_q + 2'h1;
    end
  end
  ////////////////////////////////
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  property p_en; st |-> DAC1_EN == ctl_q[7]; endproperty
  a_en: assert property (p_en) else $error("enable differs from control");
  property p_oe;
    st |-> {DAC1_PIN2_OUT_EN, DAC1_PIN1_OUT_EN} == ((ctl_q[7] && ctl_q[5:4] != 2'h3) ? ctl_q[5:4] : 2'h0);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enables wrong");
  property p_hot; DAC1_PIN1_OUT_EN |-> !DAC1_PIN2_OUT_EN; endproperty
  a_hot: assert property (p_hot) else $error("both pins driven");
  property p_nss; st |-> DAC1_NEG_REF_EXT == ctl_q[0]; endproperty
  a_nss: assert property (p_nss) else $error("negative reference wrong");
  property p_cod; st |-> DAC1_LEVEL_CODE == cod_q; endproperty
  a_cod: assert property (p_cod) else $error("level code wrong");
  property p_pss; st && DAC1_POS_REF != 3'h0 |-> ctl_q[7] && DAC1_POS_REF == (3'h1 << ctl_q[3:2]); endproperty
  a_pss: assert property (p_pss) else $error("positive reference wrong");
  property p_slp; SLEEP [*4] |-> DAC1_POS_REF == 3'h0; endproperty
  a_slp: assert property (p_slp) else $error("reference on in sleep");
  property p_rng; st && !AUTO_RANGE_CFG |-> DAC1_RANGE_HIGH == (cod_q >= DDC_AUTO_HI_CODE); endproperty
  a_rng: assert property (p_rng) else $error("auto range wrong");
  property p_rsw; st && AUTO_RANGE_CFG |-> DAC1_RANGE_HIGH == ctl_q[6]; endproperty
  a_rsw: assert property (p_rsw) else $error("software range wrong");
  property p_rst; $rose(RST_B) |-> !DAC1_EN && DAC1_LEVEL_CODE == 8'h00 && DAC1_POS_REF == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs live after reset");
endmodule
bind ddc_top ddc_checker u_ddc_checker (.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .SLEEP(SLEEP),
  .AUTO_RANGE_CFG(AUTO_RANGE_CFG), .DAC1_EN(DAC1_EN), .DAC1_LEVEL_CODE(DAC1_LEVEL_CODE),
  .DAC1_POS_REF(DAC1_POS_REF), .DAC1_NEG_REF_EXT(DAC1_NEG_REF_EXT), .DAC1_RANGE_HIGH(DAC1_RANGE_HIGH),
  .DAC1_PIN1_OUT_EN(DAC1_PIN1_OUT_EN), .DAC1_PIN2_OUT_EN(DAC1_PIN2_OUT_EN));
`default_nettype wire

// File: verification/dual_dac_control_test.sv
/* Self-checking bench for ddc_top through classic Wishbone cycles.
   Assumes ddc_pkg, ddc_top and ddc_checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dual_dac_control_test
  import ddc_pkg::*;
;
  logic                clk, rst_b, cyc, stb, we, ack, slp, acfg;
  logic [13:0]         adr;
  logic [3:0]          sel;
  logic [31:0]         dati, dato;
  logic                en1, neg1, rng1, p1, p2, en2, neg2;
  logic [7:0]          lc1, lc2, rd, c, v1;
  logic [DDC_NREF-1:0] pos1, pos2;
  int                  n_errors, samples_checked, cycles;
  localparam logic [13:0] ad_c1 = {DDC_IDX_CTRL1, 2'h0};
  localparam logic [13:0] ad_d1 = {DDC_IDX_CODE1, 2'h0};
  localparam logic [13:0] ad_c2 = {DDC_IDX_CTRL2, 2'h0};
  localparam logic [13:0] ad_d2 = {DDC_IDX_CODE2, 2'h0};
  assign v1 = {en1, p1, p2, neg1, rng1, pos1};
  ddc_top dut (.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .SLEEP(slp),
    .AUTO_RANGE_CFG(acfg), .DAC1_EN(en1), .DAC1_LEVEL_CODE(lc1), .DAC1_POS_REF(pos1),
    .DAC1_NEG_REF_EXT(neg1), .DAC1_RANGE_HIGH(rng1), .DAC1_PIN1_OUT_EN(p1), .DAC1_PIN2_OUT_EN(p2),
    .DAC2_EN(en2), .DAC2_LEVEL_CODE(lc2), .DAC2_POS_REF(pos2), .DAC2_NEG_REF_EXT(neg2));
  ////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One classic cycle; only the watchdog ends a wait for ack
  task automatic xfer(input logic w, input logic [13:0] a, input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= a;
    sel <= s;
    dati <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = dato[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rdchk(input logic [13:0] a, input logic [7:0] e);
    xfer(1'b0, a, 4'hF, 8'h00);
    chk(rd, e);
  endtask
  // Expected DAC1 output vector, awake
  function automatic logic [7:0] exp1(input logic [7:0] k, input logic [7:0] d, input logic cf);
    logic [2:0] ps;
    ps = (k[7] && k[3:2] != 2'h3) ? 3'h1 << k[3:2] : 3'h0;
    return {k[7], k[7] && k[5:4] == 2'h1, k[7] && k[5:4] == 2'h2, k[0], cf ? k[6] : d >= 8'h80, ps};
  endfunction
  ////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
    end
  end
  initial begin
    {rst_b, cyc, stb, we, slp, acfg} = 6'h0;
    {adr, sel, dati} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(ad_c1, 8'h00);
    rdchk(ad_d1, 8'h00);
    rdchk(ad_c2, 8'h00);
    // Every OE and reference code; bit 1 written high, codes straddle the range point
    for (int i = 0; i < 4; i++) begin
      c = {2'h3, i[1:0], i[1:0], 2'h3};
      wr_both(c, 8'h7E + i[7:0]);
      chk(v1, exp1(c, 8'h7E + i[7:0], 1'b0));
      chk(lc1, 8'h7E + i[7:0]);
      rdchk(ad_c1, c & 8'hFD);
    end
    xfer(1'b1, ad_c1, 4'hF, 8'h55);
    repeat (3) @(posedge clk);
    chk(v1, exp1(8'h55, 8'h81, 1'b0));
    xfer(1'b1, ad_c2, 4'hF, 8'hC9);
    xfer(1'b1, ad_d2, 4'hF, 8'h3C);
    repeat (3) @(posedge clk);
    chk({3'h0, en2, neg2, pos2}, 8'h1C);
    chk(lc2, 8'h3C);
    chk(v1, exp1(8'h55, 8'h81, 1'b0));
    // Byte lane off and an unmapped hole are both ignored
    xfer(1'b1, ad_d1, 4'hE, 8'h00);
    rdchk(ad_d1, 8'h81);
    xfer(1'b1, 14'h2238, 4'hF, 8'hFF);
    rdchk(14'h2238, 8'h00);
    xfer(1'b1, ad_c1, 4'hF, 8'h89);
    slp <= 1'b1;
    repeat (6) @(posedge clk);
    chk({2'h0, pos1, pos2}, 8'h00);
    slp <= 1'b0;
    repeat (6) @(posedge clk);
    chk(v1, exp1(8'h89, 8'h81, 1'b0));
    rdchk(ad_d2, 8'h3C);
    // Reset in mid-run, strap now selects the software range bit
    rst_b <= 1'b0;
    acfg <= 1'b1;
    @(posedge clk);
    chk(v1 | lc1, 8'h00);
    @(posedge clk);
    rst_b <= 1'b1;
    rdchk(ad_d1, 8'h00);
    wr_both(8'h80, 8'hF0);
    chk(v1, exp1(8'h80, 8'hF0, 1'b1));
    wr_both(8'hC0, 8'h10);
    chk(v1, exp1(8'hC0, 8'h10, 1'b1));
    rdchk({DDC_IDX_STAT, 2'h0}, 8'h05);
    end_of_test();
  end
  task automatic wr_both(input logic [7:0] k, input logic [7:0] d);
    xfer(1'b1, ad_c1, 4'hF, k);
    xfer(1'b1, ad_d1, 4'hF, d);
    repeat (3) @(posedge clk);
  endtask
endmodule
`default_nettype wire
